/* File: rtl/eeprom_array.sv */
// 256 x 8 storage array with one write port and one registered read port.
// Assumes both ports are driven from the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module eeprom_array (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [eeprom_i2c_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [eeprom_i2c_pkg::DATA_W-1:0] wr_data_i,
  // Read port
  input wire logic rd_en_i,
  input wire logic [eeprom_i2c_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [eeprom_i2c_pkg::DATA_W-1:0] rd_data_o
);
  logic [eeprom_i2c_pkg::DATA_W-1:0] cells [2**eeprom_i2c_pkg::ADDR_W];

  // Cells hold their content through reset, as a non-volatile store would
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_en_i) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data stays put until the next read, so a slow reader can take it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (ce_i && rd_en_i) begin
      rd_data_o <= cells[rd_addr_i];
    end
  end
endmodule : eeprom_array
`default_nettype wire

/* File: rtl/eeprom_i2c_pkg.sv */
// Constants, timing figures and state types of the two-wire serial EEPROM slave.
// Assumes a 200 MHz system clock; the link side oversamples the bus pins.
`default_nettype none
package eeprom_i2c_pkg;

  // System clock rate
  localparam int CLK_SYS_MHZ = 200;
  localparam real US_PER_MS = 1000.0;

  // Erase/write cycle times, as typical figures
  localparam real BYTE_EW_TIME_MS = 10.0;
  localparam real PAGE_ERASE_TIME_MS = 3.5;
  localparam real PAGE_WRITE_TIME_MS = 28.0;
  localparam int BYTE_EW_CYCLES = int'(BYTE_EW_TIME_MS * US_PER_MS * CLK_SYS_MHZ);
  localparam int PAGE_ERASE_CYCLES = int'(PAGE_ERASE_TIME_MS * US_PER_MS * CLK_SYS_MHZ);
  localparam int PAGE_WRITE_CYCLES = int'(PAGE_WRITE_TIME_MS * US_PER_MS * CLK_SYS_MHZ);

  // Widths and field layout
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PAGE_LOW_W = 3;
  localparam int DIR_BIT = 0;
  localparam int TX_MSB = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] PAGE_BYTES = 4'h8;
  localparam int FILTER_LEN = 3;

  // Device-type code of the slave address; value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5;

  // Bus-side protocol states
  typedef enum logic [5:0] {
    LS_IDLE = 6'h01,
    LS_RX   = 6'h02,
    LS_ACK  = 6'h04,
    LS_TX   = 6'h08,
    LS_MACK = 6'h10,
    LS_WAIT = 6'h20
  } link_state_t;

  // Which byte of the transfer is being received
  typedef enum logic [2:0] {
    PH_DEV  = 3'h1,
    PH_WORD = 3'h2,
    PH_DATA = 3'h4
  } phase_t;

  // Programming sequencer states
  typedef enum logic [2:0] {
    SS_IDLE  = 3'h1,
    SS_STORE = 3'h2,
    SS_TIME  = 3'h4
  } sys_state_t;

endpackage : eeprom_i2c_pkg
`default_nettype wire

/* File: rtl/serial_eeprom_i2c_slave.sv */
// Two-wire serial slave front end of a 256-byte EEPROM with timed erase/write.
// Assumes SCL/SDA are oversampled on clk_link_i, well above 100 kHz bus rate.
// How it works
// - SDA falling while SCL high starts transfer
// - SDA rising while SCL high stops transfer
// - Data sampled on SCL rise, stable while high
// - Eight bits MSB first, then acknowledge bit
// - Standard 100 kHz rate only, no fast mode
// - Slave pulls SDA low through acknowledge pulse
// - Master nack on last read; slave releases SDA
// - Address byte: type code, straps, direction bit
// - Direction bit one reads, zero writes
// - Write: word address byte, acked, then data
// - Timed erase/write starts at stop, 10 ms/byte
// - No acknowledge, inputs ignored while programming
// - Page write: erase 3.5 ms, write 28 ms
// - Page write wraps low three address bits
// - Ninth data byte: no ack, discard all
// - Current, random and sequential reads supported
// - Word address increments, wraps 255 to 0
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave #(
  parameter int BYTE_EW_CYCLES = eeprom_i2c_pkg::BYTE_EW_CYCLES,
  parameter int PAGE_ERASE_CYCLES = eeprom_i2c_pkg::PAGE_ERASE_CYCLES,
  parameter int PAGE_WRITE_CYCLES = eeprom_i2c_pkg::PAGE_WRITE_CYCLES,
  parameter logic [3:0] DEVICE_TYPE_CODE = eeprom_i2c_pkg::DEVICE_TYPE_CODE
) (
  // System clock domain
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link sampling clock
  input wire logic clk_link_i,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Address strap pins
  input wire logic select_strap_bit0_i,
  input wire logic select_strap_bit1_i,
  input wire logic select_strap_bit2_i,
  // Status
  output logic ew_busy_o
);
  localparam int LSYNC_W = 9;
  localparam int PTR_W = eeprom_i2c_pkg::ADDR_W;
  localparam int DW = eeprom_i2c_pkg::DATA_W;
  localparam int LW = eeprom_i2c_pkg::PAGE_LOW_W;
  localparam int FL = eeprom_i2c_pkg::FILTER_LEN;

  // Word address advance: full byte wrap
  function automatic logic [PTR_W-1:0] inc_addr(input logic [PTR_W-1:0] a);
    inc_addr = a + {{(PTR_W-1){1'b0}}, 1'b1};
  endfunction : inc_addr

  // Cross-domain handshake signals
  logic wr_req_tgl;
  logic rd_req_tgl;
  logic wr_ack_tgl;
  logic rd_ack_tgl;
  logic [DW-1:0] rd_data;
  logic [DW-1:0] pbuf [8];
  logic [3:0] count;
  logic [PTR_W-1:0] base;
  logic [PTR_W-1:0] ptr;

  // Link-side synchronisers: pins, straps, enable, reset and acknowledges
  logic [LSYNC_W-1:0] lsync1;
  logic [LSYNC_W-1:0] lsync2;
  always_ff @(posedge clk_link_i) begin
    lsync1 <= {scl_i, sda_i, select_strap_bit2_i, select_strap_bit1_i, select_strap_bit0_i,
               ce_i, rst_i, wr_ack_tgl, rd_ack_tgl};
    lsync2 <= lsync1;
  end
  logic l_scl_s;
  logic l_sda_s;
  logic [2:0] l_strap;
  logic l_ce;
  logic l_rst;
  logic l_wr_ack;
  logic l_rd_ack;
  assign {l_scl_s, l_sda_s, l_strap, l_ce, l_rst, l_wr_ack, l_rd_ack} = lsync2;

  // Write pending keeps the link deaf until programming completes
  logic wr_pend;
  assign wr_pend = wr_req_tgl ^ l_wr_ack;

  // Link state
  eeprom_i2c_pkg::link_state_t lst, next_lst;
  eeprom_i2c_pkg::phase_t phase, next_phase;
  logic [FL-1:0] scl_h, next_scl_h;
  logic [FL-1:0] sda_h, next_sda_h;
  logic scl_f, next_scl_f;
  logic sda_f, next_sda_f;
  logic scl_p, next_scl_p;
  logic sda_p, next_sda_p;
  logic [DW-1:0] shift, next_shift;
  logic [3:0] bitcnt, next_bitcnt;
  logic rw, next_rw;
  logic discard, next_discard;
  logic mack, next_mack;
  logic oe, next_oe;
  logic [3:0] next_count;
  logic [PTR_W-1:0] next_base;
  logic [PTR_W-1:0] next_ptr;
  logic [DW-1:0] next_pbuf [8];
  logic next_wr_req;
  logic next_rd_req;

  // Bus events from the filtered lines
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;

  // Bus protocol: filter, decode and byte handling
  always_comb begin
    next_scl_h = {scl_h[FL-2:0], l_scl_s};
    next_sda_h = {sda_h[FL-2:0], l_sda_s};
    // Spikes shorter than the window are dropped; sized for standard mode only
    next_scl_f = (&scl_h) ? 1'b1 : ((|scl_h) ? scl_f : 1'b0);
    next_sda_f = (&sda_h) ? 1'b1 : ((|sda_h) ? sda_f : 1'b0);
    next_scl_p = scl_f;
    next_sda_p = sda_f;
    next_lst = lst;
    next_phase = phase;
    next_shift = shift;
    next_bitcnt = bitcnt;
    next_rw = rw;
    next_discard = discard;
    next_mack = mack;
    next_oe = oe;
    next_count = count;
    next_base = base;
    next_ptr = ptr;
    next_pbuf = pbuf;
    next_wr_req = wr_req_tgl;
    next_rd_req = rd_req_tgl;
    if (wr_pend) begin
      // Programming in progress: every bus input ignored
      next_lst = eeprom_i2c_pkg::LS_IDLE;
      next_oe = 1'b0;
    end else if (start_ev) begin
      // A repeated start keeps the pointer, so random reads work
      next_lst = eeprom_i2c_pkg::LS_RX;
      next_phase = eeprom_i2c_pkg::PH_DEV;
      next_bitcnt = '0;
      next_count = '0;
      next_discard = 1'b0;
      next_oe = 1'b0;
    end else if (stop_ev) begin
      next_lst = eeprom_i2c_pkg::LS_IDLE;
      next_oe = 1'b0;
      if (!rw && !discard && count != '0 && phase == eeprom_i2c_pkg::PH_DATA) begin
        next_wr_req = ~wr_req_tgl;
        if (count == eeprom_i2c_pkg::PAGE_BYTES) begin
          next_ptr = base;
        end
      end
    end else begin
      unique case (lst)
        eeprom_i2c_pkg::LS_IDLE, eeprom_i2c_pkg::LS_WAIT: begin
          next_oe = 1'b0;
        end
        eeprom_i2c_pkg::LS_RX: begin
          if (scl_rise && bitcnt != eeprom_i2c_pkg::BITS_PER_BYTE) begin
            next_shift = {shift[DW-2:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == eeprom_i2c_pkg::BITS_PER_BYTE) begin
            next_lst = eeprom_i2c_pkg::LS_ACK;
            next_oe = 1'b1;
            unique case (phase)
              eeprom_i2c_pkg::PH_DEV: begin
                if (shift[DW-1:1] != {DEVICE_TYPE_CODE, l_strap}) begin
                  next_lst = eeprom_i2c_pkg::LS_WAIT;
                  next_oe = 1'b0;
                end else begin
                  next_rw = shift[eeprom_i2c_pkg::DIR_BIT];
                  if (shift[eeprom_i2c_pkg::DIR_BIT]) begin
                    next_rd_req = ~rd_req_tgl;
                  end
                end
              end
              eeprom_i2c_pkg::PH_WORD: begin
                next_ptr = shift;
                next_base = shift;
              end
              default: begin
                if (count == eeprom_i2c_pkg::PAGE_BYTES) begin
                  // Excess byte: left unacknowledged, whole transfer dropped
                  next_discard = 1'b1;
                  next_lst = eeprom_i2c_pkg::LS_WAIT;
                  next_oe = 1'b0;
                end else begin
                  next_pbuf[count[LW-1:0]] = shift;
                  next_count = count + 4'h1;
                  next_ptr = inc_addr(ptr);
                end
              end
            endcase
          end
        end
        eeprom_i2c_pkg::LS_ACK: begin
          if (scl_fall) begin
            next_bitcnt = '0;
            if (rw && phase == eeprom_i2c_pkg::PH_DEV) begin
              next_lst = eeprom_i2c_pkg::LS_TX;
              next_shift = rd_data;
              next_oe = ~rd_data[eeprom_i2c_pkg::TX_MSB];
            end else begin
              next_lst = eeprom_i2c_pkg::LS_RX;
              next_oe = 1'b0;
              next_phase = (phase == eeprom_i2c_pkg::PH_DEV) ? eeprom_i2c_pkg::PH_WORD
                                                            : eeprom_i2c_pkg::PH_DATA;
            end
          end
        end
        eeprom_i2c_pkg::LS_TX: begin
          if (scl_fall) begin
            if (bitcnt == eeprom_i2c_pkg::BIT_LAST) begin
              next_lst = eeprom_i2c_pkg::LS_MACK;
              next_oe = 1'b0;
              next_ptr = inc_addr(ptr);
              next_rd_req = ~rd_req_tgl;
            end else begin
              next_shift = {shift[DW-2:0], 1'b0};
              next_oe = ~shift[DW-2];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        eeprom_i2c_pkg::LS_MACK: begin
          if (scl_rise) begin
            next_mack = ~sda_f;
          end else if (scl_fall) begin
            next_bitcnt = '0;
            if (mack) begin
              next_lst = eeprom_i2c_pkg::LS_TX;
              next_shift = rd_data;
              next_oe = ~rd_data[eeprom_i2c_pkg::TX_MSB];
            end else begin
              next_lst = eeprom_i2c_pkg::LS_WAIT;
              next_oe = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Link registers; the synchronisers above keep running while frozen
  always_ff @(posedge clk_link_i) begin
    if (l_rst) begin
      lst <= eeprom_i2c_pkg::LS_IDLE;
      phase <= eeprom_i2c_pkg::PH_DEV;
      scl_h <= '1;
      sda_h <= '1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      shift <= '0;
      bitcnt <= '0;
      rw <= 1'b0;
      discard <= 1'b0;
      mack <= 1'b0;
      oe <= 1'b0;
      count <= '0;
      base <= '0;
      ptr <= '0;
      pbuf <= '{default: '0};
      wr_req_tgl <= 1'b0;
      rd_req_tgl <= 1'b0;
    end else if (l_ce) begin
      lst <= next_lst;
      phase <= next_phase;
      scl_h <= next_scl_h;
      sda_h <= next_sda_h;
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_p <= next_scl_p;
      sda_p <= next_sda_p;
      shift <= next_shift;
      bitcnt <= next_bitcnt;
      rw <= next_rw;
      discard <= next_discard;
      mack <= next_mack;
      oe <= next_oe;
      count <= next_count;
      base <= next_base;
      ptr <= next_ptr;
      pbuf <= next_pbuf;
      wr_req_tgl <= next_wr_req;
      rd_req_tgl <= next_rd_req;
    end
  end
  // Open-drain pad: only ever pulls low
  assign sda_oe_o = oe;
  assign sda_o = 1'b0 & oe;

  // System-side synchronisers for the two request toggles, plus edge stage
  logic [1:0] ssync1;
  logic [1:0] ssync2;
  logic [1:0] ssync3;
  always_ff @(posedge clk_sys_i) begin
    ssync1 <= {rd_req_tgl, wr_req_tgl};
    ssync2 <= ssync1;
    ssync3 <= ssync2;
  end
  logic wr_evt;
  logic rd_evt;
  assign wr_evt = ssync2[0] ^ ssync3[0];
  assign rd_evt = ssync2[1] ^ ssync3[1];

  // Programming sequencer state
  eeprom_i2c_pkg::sys_state_t sst, next_sst;
  logic [2:0] idx, next_idx;
  logic [31:0] timer, next_timer;
  logic busy, next_busy;
  logic rd_stage, next_rd_stage;
  logic next_wr_ack;
  logic next_rd_ack;
  logic page_mode;
  logic mem_wr_en;
  logic [PTR_W-1:0] mem_wr_addr;
  assign page_mode = (count == eeprom_i2c_pkg::PAGE_BYTES);

  // Store buffered bytes, then hold busy for the timed cycle
  always_comb begin
    next_sst = sst;
    next_idx = idx;
    next_timer = timer;
    next_busy = busy;
    next_rd_stage = rd_evt;
    next_wr_ack = wr_ack_tgl;
    next_rd_ack = rd_stage ? ~rd_ack_tgl : rd_ack_tgl;
    mem_wr_en = 1'b0;
    mem_wr_addr = page_mode ? {base[PTR_W-1:LW], base[LW-1:0] + idx}
                            : base + {{(PTR_W-LW){1'b0}}, idx};
    unique case (sst)
      eeprom_i2c_pkg::SS_IDLE: begin
        if (wr_evt) begin
          next_sst = eeprom_i2c_pkg::SS_STORE;
          next_idx = '0;
          next_busy = 1'b1;
        end
      end
      eeprom_i2c_pkg::SS_STORE: begin
        mem_wr_en = 1'b1;
        next_idx = idx + 3'h1;
        if ({1'b0, idx} == count - 4'h1) begin
          next_sst = eeprom_i2c_pkg::SS_TIME;
          next_timer = page_mode ? 32'(PAGE_ERASE_CYCLES + PAGE_WRITE_CYCLES)
                                 : 32'(32'(count) * 32'(BYTE_EW_CYCLES));
        end
      end
      eeprom_i2c_pkg::SS_TIME: begin
        next_timer = timer - 32'h1;
        if (timer == 32'h1) begin
          next_sst = eeprom_i2c_pkg::SS_IDLE;
          next_busy = 1'b0;
          next_wr_ack = ~wr_ack_tgl;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sst <= eeprom_i2c_pkg::SS_IDLE;
      idx <= '0;
      timer <= '0;
      busy <= 1'b0;
      rd_stage <= 1'b0;
      wr_ack_tgl <= 1'b0;
      rd_ack_tgl <= 1'b0;
    end else if (ce_i) begin
      sst <= next_sst;
      idx <= next_idx;
      timer <= next_timer;
      busy <= next_busy;
      rd_stage <= next_rd_stage;
      wr_ack_tgl <= next_wr_ack;
      rd_ack_tgl <= next_rd_ack;
    end
  end
  assign ew_busy_o = busy;

  // Storage; read address is the link pointer, held still by the handshake
  eeprom_array u_array (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_en_i(mem_wr_en),
    .wr_addr_i(mem_wr_addr),
    .wr_data_i(pbuf[idx]),
    .rd_en_i(rd_evt),
    .rd_addr_i(ptr),
    .rd_data_o(rd_data)
  );
endmodule : serial_eeprom_i2c_slave
`default_nettype wire

/* File: verification/bus_master_model.sv */
// Two-wire bus master model: drives the clock and pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
  parameter int QTR_NS = 250
) (
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // Bus idle: both lines high
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Data set mid-low, held over the high phase, sampled mid-high
  task automatic bit_xfer(input logic b, output logic s);
    sda_pull_o = !b;
    #(QTR_NS) scl_o = 1'b1;
    #(QTR_NS) s = sda_i;
    #(QTR_NS) scl_o = 1'b0;
    #(QTR_NS);
  endtask : bit_xfer
  // Data falls with clock high; doubles as repeated start
  task automatic start_cond();
    sda_pull_o = 1'b0;
    #(QTR_NS) scl_o = 1'b1;
    #(QTR_NS) sda_pull_o = 1'b1;
    #(QTR_NS) scl_o = 1'b0;
    #(QTR_NS);
  endtask : start_cond
  // Data rises with clock high, leaving the bus idle
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #(QTR_NS) scl_o = 1'b1;
    #(QTR_NS) sda_pull_o = 1'b0;
    #(2 * QTR_NS);
  endtask : stop_cond
  // Eight bits first to last, then the acknowledge clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, ack);
  endtask : send_byte
  // Master acknowledges all but the last byte
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, b[i]);
    end
    bit_xfer(last, s);
  endtask : recv_byte
endmodule : bus_master_model
`default_nettype wire

/* File: verification/eeprom_slave_assertions.sv */
// Checker for the two-wire EEPROM slave: acknowledge timing and busy window.
// Assumes binding to serial_eeprom_i2c_slave; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_assertions #(
  parameter int BYTE_EW_CYCLES = 2000,
  parameter int PAGE_ERASE_CYCLES = 400,
  parameter int PAGE_WRITE_CYCLES = 1600
) (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic clk_link_i,
  input wire logic rst_i,
  // Bus pins and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_o,
  input wire logic ew_busy_o
);
  localparam int BUSY_MAX = 7 * BYTE_EW_CYCLES + PAGE_ERASE_CYCLES + PAGE_WRITE_CYCLES + 64;
  logic [31:0] busy_len;
  logic [31:0] next_busy_len;
  // Busy length; zeroed only after the fall so the fall cycle still sees it
  always_comb begin
    next_busy_len = ew_busy_o ? busy_len + 32'h1 : 32'h0;
    if (rst_i) begin
      next_busy_len = 32'h0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    busy_len <= next_busy_len;
  end
  sequence ack_hold_s;
    sda_oe_o [*8];
  endsequence
  sequence busy_run_s;
    ew_busy_o [*8];
  endsequence
  // Outputs quiet once reset has reached both domains
  reset_quiet_a:
    assert property (@(posedge clk_sys_i) rst_i [*6] |=> !ew_busy_o && !sda_oe_o)
    else $error("outputs active during reset");
  busy_no_ack_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i) ew_busy_o |-> !sda_oe_o)
    else $error("data pulled low while busy");
  oe_after_fall_a:
    assert property (@(posedge clk_link_i) disable iff (rst_i)
      $changed(sda_oe_o) |-> !scl_i && $past(scl_i, 10)) else $error("data moved off clock fall");
  ack_hold_a:
    assert property (@(posedge clk_link_i) disable iff (rst_i)
      $rose(scl_i) && sda_oe_o |=> ack_hold_s) else $error("low level not held while clock high");
  busy_min_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(ew_busy_o) |-> busy_len >= PAGE_ERASE_CYCLES + PAGE_WRITE_CYCLES
        || busy_len >= BYTE_EW_CYCLES) else $error("erase/write cycle too short");
  busy_max_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i) ew_busy_o |-> busy_len < BUSY_MAX)
    else $error("erase/write cycle too long");
  busy_at_stop_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i) $rose(ew_busy_o) |-> scl_i && sda_i)
    else $error("busy started on a busy bus");
  busy_hold_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i) $rose(ew_busy_o) |=> busy_run_s)
    else $error("busy pulse too short");
endmodule : eeprom_slave_assertions
bind serial_eeprom_i2c_slave eeprom_slave_assertions #(
  .BYTE_EW_CYCLES(BYTE_EW_CYCLES),
  .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES),
  .PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES)
) eeprom_slave_assertions_inst (
  .clk_sys_i(clk_sys_i),
  .clk_link_i(clk_link_i),
  .rst_i(rst_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_oe_o(sda_oe_o),
  .ew_busy_o(ew_busy_o)
);
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the two-wire EEPROM slave, with a bus master model.
// Assumes the design package is compiled first; both clocks run free.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BYTE_CYC = 2000;
  localparam int PAGE_CYC = 2000;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] strap = STRAP;
  logic scl;
  logic m_pull;
  logic sda_oe;
  logic sda_out;
  logic busy;
  logic sda;
  logic [7:0] d;
  logic a;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int busy_cyc = 0;
  // Open-drain wire with pull-up
  assign sda = (m_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  // Short erase/write counts keep the run brief
  serial_eeprom_i2c_slave #(.BYTE_EW_CYCLES(BYTE_CYC), .PAGE_ERASE_CYCLES(400),
    .PAGE_WRITE_CYCLES(1600)) serial_eeprom_i2c_slave_inst (.clk_sys_i(clk_sys),
    .rst_i(rst), .ce_i(ce), .clk_link_i(clk_link), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .select_strap_bit0_i(strap[0]),
    .select_strap_bit1_i(strap[1]), .select_strap_bit2_i(strap[2]), .ew_busy_o(busy));
  // 150 ns quarters keep each low phase above the read handshake, and the run short
  bus_master_model #(.QTR_NS(150)) bus_master_model_inst (.sda_i(sda), .scl_o(scl),
    .sda_pull_o(m_pull));
  initial begin
    forever #2.5 clk_sys = !clk_sys;
  end
  // Link clock offset so the two never line up
  initial begin
    #1.3;
    forever #6 clk_link = !clk_link;
  end
  // Hang guard; a clean run needs about 70k cycles. Busy cycles counted alongside
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      busy_cyc <= busy_cyc + 1;
    end
    if (cycles == 90000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_val(what, {7'h0, exp}, {7'h0, got});
  endtask : check_bit
  task automatic tx(input logic [7:0] b, input logic exp_ack);
    bus_master_model_inst.send_byte(b, a);
    check_bit("acknowledge", !exp_ack, a);
  endtask : tx
  task automatic rx(input logic last, input logic [7:0] exp);
    bus_master_model_inst.recv_byte(last, d);
    check_val("read data", exp, d);
  endtask : rx
  // Busy waits; a few cycles more after the fall for the handshake to settle
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 20000 && busy !== lvl; n++) begin
      @(negedge clk_sys);
    end
    repeat (20) @(negedge clk_sys);
  endtask : wait_busy
  task automatic begin_xfer(input logic rd);
    bus_master_model_inst.start_cond();
    tx({eeprom_i2c_pkg::DEVICE_TYPE_CODE, STRAP, rd}, 1'b1);
  endtask : begin_xfer
  task automatic set_pointer(input logic [7:0] w);
    begin_xfer(1'b0);
    tx(w, 1'b1);
  endtask : set_pointer
  // Three bytes across the top of the array, probed while busy
  // Busy rises inside stop_cond, so its span is counted per cycle, not timed from a call
  task automatic test_byte_write();
    set_pointer(8'hfe);
    for (int i = 0; i < 3; i++) begin
      tx(8'(8'hfe + i) ^ 8'h5a, 1'b1);
    end
    busy_cyc = 0;
    bus_master_model_inst.stop_cond();
    wait_busy(1'b1);
    bus_master_model_inst.start_cond();
    tx({eeprom_i2c_pkg::DEVICE_TYPE_CODE, STRAP, 1'b0}, 1'b0);
    bus_master_model_inst.stop_cond();
    wait_busy(1'b0);
    check_bit("busy span", 1'b1, busy_cyc >= 3 * BYTE_CYC);
    check_bit("busy bound", 1'b1, busy_cyc < 3 * BYTE_CYC + 60);
  endtask : test_byte_write
  task automatic test_random_read();
    set_pointer(8'hfe);
    begin_xfer(1'b1);
    for (int i = 0; i < 3; i++) begin
      rx(i == 2, 8'(8'hfe + i) ^ 8'h5a);
    end
    check_bit("released after last byte", 1'b0, sda_oe);
    bus_master_model_inst.stop_cond();
  endtask : test_random_read
  task automatic test_wrong_strap();
    for (int b = 0; b < 3; b++) begin
      bus_master_model_inst.start_cond();
      tx({eeprom_i2c_pkg::DEVICE_TYPE_CODE, STRAP ^ 3'(1 << b), 1'b0}, 1'b0);
      bus_master_model_inst.stop_cond();
    end
  endtask : test_wrong_strap
  // Page from a mid-page base, then current and sequential reads
  task automatic test_page_write();
    set_pointer(8'h15);
    for (int i = 0; i < 8; i++) begin
      tx(8'h80 + 8'(i), 1'b1);
    end
    busy_cyc = 0;
    bus_master_model_inst.stop_cond();
    wait_busy(1'b1);
    check_bit("page busy", 1'b1, busy);
    wait_busy(1'b0);
    check_bit("page span", 1'b1, busy_cyc >= PAGE_CYC && busy_cyc < PAGE_CYC + 60);
    begin_xfer(1'b1);
    rx(1'b1, 8'h80);
    bus_master_model_inst.stop_cond();
    set_pointer(8'h10);
    begin_xfer(1'b1);
    for (int j = 0; j < 8; j++) begin
      rx(j == 7, 8'h80 + 8'((j + 3) % 8));
    end
    bus_master_model_inst.stop_cond();
  endtask : test_page_write
  task automatic test_ninth_byte();
    set_pointer(8'h10);
    for (int i = 0; i < 9; i++) begin
      tx(8'h40 + 8'(i), i < 8);
    end
    bus_master_model_inst.stop_cond();
    repeat (200) @(negedge clk_sys);
    check_bit("busy after discard", 1'b0, busy);
    set_pointer(8'h10);
    begin_xfer(1'b1);
    rx(1'b1, 8'h83);
    bus_master_model_inst.stop_cond();
  endtask : test_ninth_byte
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (200) @(negedge clk_sys);
    test_byte_write();
    test_random_read();
    test_wrong_strap();
    test_page_write();
    test_ninth_byte();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
